// ### aioc_pkg.sv
// shared constants for the analog i/o register controller: map, codes, timing
// assumes one 125 mhz clock shared by the device end, the host end and the link
//
// Functional notes
// - eight inputs, sixteen-bit readings each
// - volt mode: 0..5.5 V reads 0..55000
// - current mode: 0..40 mA reads 0..40000
// - mode code: 0 raw, 1 mA, 2 volt
// - mode settings kept in nonvolatile store; an operator change made in the same cycle as a host mode write is not stored
// - mode picks the scaling table applied
// - totalizer adds reading once per interval
// - one writable register sets sampling interval
// - totalizer 32 bits, odd register is MSB
// - host writes outputs 4000..20000 only
// - output numerator over fixed 65535 denominator
// - separate output offset register range
// - input readings read-only, channel order
// - supply voltage readback in tenths volt
// - host ignores factory test registers
// - channels forceable locally, forced flag shown
// - local interface sets each input mode
// - inputs refreshed about twice per second
// - outputs driven with twelve-bit codes
// - outputs updated about hundred times per second
package aioc_pkg;
  localparam int NCH  = 8;
  localparam int NCAL = 6;
  localparam int DW   = 16;
  localparam int DACW = 12;
  // register offsets, holding space
  localparam logic [7:0] ADR_SETPT = 8'h01;
  localparam logic [7:0] ADR_TOT   = 8'h11;
  localparam logic [7:0] ADR_INTV  = 8'h84;
  localparam logic [7:0] ADR_MODE  = 8'h85;
  localparam logic [7:0] ADR_CALN  = 8'hA1;
  localparam logic [7:0] ADR_CALO  = 8'hBA;
  // register offsets, input space
  localparam logic [7:0] ADR_AIN    = 8'h01;
  localparam logic [7:0] ADR_RSVD   = 8'hF8;
  localparam logic [7:0] ADR_SUPPLY = 8'hFA;
  // mode codes and scaling gains (reading = raw * gain / 65536)
  localparam logic [1:0]  MODE_RAW  = 2'h0;
  localparam logic [1:0]  MODE_MA   = 2'h1;
  localparam logic [1:0]  MODE_VOLT = 2'h2;
  localparam logic [15:0] MODE_MAX  = 16'h0002;
  localparam logic [15:0] GAIN_MA   = 16'h9C40;
  localparam logic [15:0] GAIN_VOLT = 16'hD6D8;
  // setpoint range and reset values
  localparam logic [15:0] SP_MIN    = 16'h0FA0;
  localparam logic [15:0] SP_MAX    = 16'h4E20;
  localparam logic [15:0] CALN_RST  = 16'hFFFF;
  localparam logic [15:0] CALO_RST  = 16'h0000;
  localparam logic [15:0] INTV_RST  = 16'h0001;
  localparam logic [11:0] DAC_MAX   = 12'hFFF;
  // local operator commands
  localparam logic [1:0] OP_FORCE_IN  = 2'h0;
  localparam logic [1:0] OP_FORCE_OUT = 2'h1;
  localparam logic [1:0] OP_RELEASE   = 2'h2;
  localparam logic [1:0] OP_SET_MODE  = 2'h3;
  // timing
  localparam int CLK_HZ         = 125_000_000;
  localparam int INTV_UNIT_MS   = 1;
  localparam int AIN_PERIOD_MS  = 500;
  localparam int AOUT_PERIOD_MS = 10;
  localparam int MS_CYC   = CLK_HZ / 1000 * INTV_UNIT_MS;
  localparam int AIN_CYC  = CLK_HZ / 1000 * AIN_PERIOD_MS / NCH;
  localparam int AOUT_CYC = CLK_HZ / 1000 * AOUT_PERIOD_MS;
  // host sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } aioc_hst_t;
endpackage : aioc_pkg

// ### aioc_if.sv
// register link between the host controller end and the device end
// assumes both ends run on the same clock; one request, one answer
`timescale 1ns/100ps
interface aioc_if;
  logic        req;
  logic        we;
  logic        inreg;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic        err;
  logic [15:0] rdata;
  modport dev (input req, we, inreg, addr, wdata, output ack, err, rdata);
  modport hst (output req, we, inreg, addr, wdata, input ack, err, rdata);
endinterface : aioc_if

// ### aioc_scale.sv
// output calibration: setpoint times numerator over 65535 plus offset
// assumes offset is two's complement; result saturates to the dac range
`timescale 1ns/100ps
module aioc_scale (
  input  wire logic [15:0] i_setpt,
  input  wire logic [15:0] i_num,
  input  wire logic [15:0] i_off,
  output logic      [11:0] o_code
);
  logic [31:0]        prod;
  logic [32:0]        rnd;
  logic [16:0]        quot;
  logic signed [18:0] sum;

  // divide by 65535 exactly through the add-shift identity
  assign prod = i_setpt * i_num;
  assign rnd  = {1'b0, prod} + {17'h0_0000, prod[31:16]} + 33'h0_0000_0001;
  assign quot = rnd[32:16];
  assign sum  = $signed({2'b00, quot}) + $signed({{3{i_off[15]}}, i_off});
  // clamp into twelve bits
  assign o_code = sum[18] ? 12'h000 :
                  (sum > $signed({7'h00, aioc_pkg::DAC_MAX})) ? aioc_pkg::DAC_MAX :
                  sum[11:0];
endmodule : aioc_scale

// ### aioc_device.sv
// device end: register file, input scaling, totalizers, output drive
// assumes adc handshake and supply level arrive from pins; operator and
// nonvolatile ports are logic on the same clock
`timescale 1ns/100ps
module aioc_device #(
  parameter int N       = aioc_pkg::NCH,
  parameter int N_CAL   = aioc_pkg::NCAL,
  parameter int MS_CYC  = aioc_pkg::MS_CYC,
  parameter int AIN_CYC = aioc_pkg::AIN_CYC,
  parameter int AOUT_CYC = aioc_pkg::AOUT_CYC
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  aioc_if.dev                  bus,
  output logic                 o_adc_start,
  output logic [2:0]           o_adc_ch,
  input  wire logic            i_adc_done,
  input  wire logic [15:0]     i_adc_data,
  input  wire logic [15:0]     i_supply_tenths,
  input  wire logic [2*N-1:0]  i_nv_mode,
  output logic                 o_nv_we,
  output logic [2:0]           o_nv_ch,
  output logic [1:0]           o_nv_mode,
  input  wire logic            i_op_valid,
  input  wire logic [1:0]      i_op_cmd,
  input  wire logic [2:0]      i_op_ch,
  input  wire logic [15:0]     i_op_data,
  output logic [N-1:0]         o_forced_in,
  output logic [N-1:0]         o_forced_out,
  output logic [12*N-1:0]      o_dac_code,
  output logic                 o_dac_upd
);
  localparam int MSW = $clog2(MS_CYC);
  localparam int AIW = $clog2(AIN_CYC);
  localparam int AOW = $clog2(AOUT_CYC);

  function automatic logic in_win(input logic [7:0] a, input logic [7:0] base, input int n);
    in_win = (int'(a) >= int'(base)) && (int'(a) < int'(base) + n);
  endfunction : in_win

  function automatic logic [15:0] scale_in(input logic [1:0] m, input logic [15:0] raw);
    logic [31:0] p;
    p = 32'h0000_0000;
    if (m == aioc_pkg::MODE_MA)
      p = raw * aioc_pkg::GAIN_MA;
    else if (m == aioc_pkg::MODE_VOLT)
      p = raw * aioc_pkg::GAIN_VOLT;
    else
      p = {raw, 16'h0000};                                        // raw code
    scale_in = p[31:16];
  endfunction : scale_in

  logic [15:0] setpt [N];
  logic [15:0] cal_num [N];
  logic [15:0] cal_off [N];
  logic [15:0] scaled [N];
  logic [15:0] fin_val [N];
  logic [15:0] fout_val [N];
  logic [15:0] rd_in [N];
  logic [31:0] tot [N];
  logic [1:0]  mode [N];
  logic [11:0] code [N];
  logic [15:0] intv;
  logic [15:0] intv_cnt;
  logic [15:0] stage_hi;
  logic        nv_loaded;
  logic        done_s1, done_s2, done_s3;
  logic [15:0] data_s1, data_s2;
  logic [15:0] sup_s1, sup_s2;
  logic [MSW-1:0] ms_cnt;
  logic [AIW-1:0] ai_cnt;
  logic [AOW-1:0] ao_cnt;

  // pin inputs pass two flops
  always_ff @(posedge i_clk)
  begin
    done_s1 <= i_adc_done;
    done_s2 <= done_s1;
    done_s3 <= done_s2;
    data_s1 <= i_adc_data;
    data_s2 <= data_s1;
    sup_s1  <= i_supply_tenths;
    sup_s2  <= sup_s1;
  end

  // address decode
  wire [7:0] a        = bus.addr;
  wire       hold     = !bus.inreg;
  wire       hit_sp   = hold && in_win(a, aioc_pkg::ADR_SETPT, N);
  wire       hit_tot  = hold && in_win(a, aioc_pkg::ADR_TOT, 2 * N);
  wire       hit_intv = hold && (a == aioc_pkg::ADR_INTV);
  wire       hit_mode = hold && in_win(a, aioc_pkg::ADR_MODE, N);
  wire       hit_caln = hold && in_win(a, aioc_pkg::ADR_CALN, N_CAL);
  wire       hit_calo = hold && in_win(a, aioc_pkg::ADR_CALO, N_CAL);
  wire       hit_ain  = bus.inreg && in_win(a, aioc_pkg::ADR_AIN, N);
  wire       hit_rsvd = bus.inreg && in_win(a, aioc_pkg::ADR_RSVD, 2);
  wire       hit_sup  = bus.inreg && (a == aioc_pkg::ADR_SUPPLY);
  wire [2:0] ix_sp    = 3'(a - aioc_pkg::ADR_SETPT);
  wire [3:0] ix_tot   = 4'(a - aioc_pkg::ADR_TOT);
  wire [2:0] ix_mode  = 3'(a - aioc_pkg::ADR_MODE);
  wire [2:0] ix_caln  = 3'(a - aioc_pkg::ADR_CALN);
  wire [2:0] ix_calo  = 3'(a - aioc_pkg::ADR_CALO);
  wire [2:0] ix_ain   = 3'(a - aioc_pkg::ADR_AIN);
  wire       mapped   = hit_sp | hit_tot | hit_intv | hit_mode | hit_caln | hit_calo |
                        hit_ain | hit_rsvd | hit_sup;
  wire       bad_wr   = bus.we && (bus.inreg || (hit_mode && bus.wdata > aioc_pkg::MODE_MAX));
  wire       err_w    = !mapped || bad_wr;
  wire       wr       = bus.req && bus.we && !err_w;

  // read selection; odd totalizer register carries the upper half
  wire [31:0] tot_sel = tot[ix_tot[3:1]];
  wire [15:0] rd_val  = hit_sp   ? setpt[ix_sp] :
                        hit_tot  ? (ix_tot[0] ? tot_sel[15:0] : tot_sel[31:16]) :
                        hit_intv ? intv :
                        hit_mode ? {14'h0000, mode[ix_mode]} :
                        hit_caln ? cal_num[ix_caln] :
                        hit_calo ? cal_off[ix_calo] :
                        hit_ain  ? rd_in[ix_ain] :
                        hit_sup  ? sup_s2 :
                        16'h0000;                                                   // reserved reads zero

  // answer one cycle after the request
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bus.ack   <= 1'b0;
      bus.err   <= 1'b0;
      bus.rdata <= 16'h0000;
    end
    else
    begin
      bus.ack   <= bus.req;
      bus.err   <= bus.req && err_w;
      bus.rdata <= (bus.req && !bus.we) ? rd_val : 16'h0000;
    end
  end

  // interval, upper-half staging and nonvolatile load flag
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      intv      <= aioc_pkg::INTV_RST;
      stage_hi  <= 16'h0000;
      nv_loaded <= 1'b0;
    end
    else
    begin
      nv_loaded <= 1'b1;
      if (wr && hit_intv)
        intv <= bus.wdata;
      if (wr && hit_tot && !ix_tot[0])
        stage_hi <= bus.wdata;
    end
  end

  // totalizer sampling tick: millisecond base times interval
  wire ms_tick  = (ms_cnt == MSW'(MS_CYC - 1));
  wire acc_tick = ms_tick && (intv != 16'h0000) && (intv_cnt >= intv - 16'h0001);
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ms_cnt   <= '0;
      intv_cnt <= 16'h0000;
    end
    else
    begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
      if (ms_tick)
        intv_cnt <= acc_tick ? 16'h0000 : intv_cnt + 16'h0001;
    end
  end

  // conversion pacing: one start per channel slot, channels in turn
  wire adc_evt = done_s2 && !done_s3;
  wire ai_tick = (ai_cnt == AIW'(AIN_CYC - 1));
  wire ao_tick = (ao_cnt == AOW'(AOUT_CYC - 1));
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ai_cnt      <= '0;
      ao_cnt      <= '0;
      o_adc_start <= 1'b0;
      o_adc_ch    <= 3'h7;
      o_dac_upd   <= 1'b0;
    end
    else
    begin
      ai_cnt      <= ai_tick ? '0 : ai_cnt + 1'b1;
      ao_cnt      <= ao_tick ? '0 : ao_cnt + 1'b1;
      o_adc_start <= ai_tick;
      o_dac_upd   <= ao_tick;
      if (ai_tick)
        o_adc_ch <= o_adc_ch + 3'h1;
    end
  end

  // host and operator mode changes reported to the nonvolatile store, only the host's when both come in one cycle
  wire op_mode_ok = i_op_valid && (i_op_cmd == aioc_pkg::OP_SET_MODE) &&
                    (i_op_data <= aioc_pkg::MODE_MAX);
  wire host_mode  = wr && hit_mode;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_nv_we   <= 1'b0;
      o_nv_ch   <= 3'h0;
      o_nv_mode <= aioc_pkg::MODE_RAW;
    end
    else
    begin
      o_nv_we   <= nv_loaded && (host_mode || op_mode_ok);
      o_nv_ch   <= host_mode ? ix_mode : i_op_ch;
      o_nv_mode <= host_mode ? bus.wdata[1:0] : i_op_data[1:0];
    end
  end

  // per-channel state
  for (genvar g = 0; g < N; g++)
  begin : g_ch
    wire sel_op = i_op_valid && (i_op_ch == 3'(g));
    assign rd_in[g] = o_forced_in[g] ? fin_val[g] : scaled[g];

    // mode: loaded from store after reset, then host or operator
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        mode[g] <= aioc_pkg::MODE_RAW;
      else if (!nv_loaded)
        mode[g] <= i_nv_mode[2*g +: 2];
      else if (host_mode && ix_mode == 3'(g))
        mode[g] <= bus.wdata[1:0];
      else if (op_mode_ok && sel_op)
        mode[g] <= i_op_data[1:0];
    end

    // conversion result scaled by this channel's mode
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        scaled[g] <= 16'h0000;
      else if (adc_evt && o_adc_ch == 3'(g))
        scaled[g] <= scale_in(mode[g], data_s2);
    end

    // totalizer: host pair load wins over accumulation
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        tot[g] <= 32'h0000_0000;
      else if (wr && hit_tot && ix_tot[0] && ix_tot[3:1] == 3'(g))
        tot[g] <= {stage_hi, bus.wdata};
      else if (acc_tick)
        tot[g] <= tot[g] + {16'h0000, rd_in[g]};
    end

    // setpoint and calibration registers
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        setpt[g]   <= aioc_pkg::SP_MIN;
        cal_num[g] <= aioc_pkg::CALN_RST;
        cal_off[g] <= aioc_pkg::CALO_RST;
      end
      else
      begin
        if (wr && hit_sp && ix_sp == 3'(g))
          setpt[g] <= bus.wdata;
        if (wr && hit_caln && ix_caln == 3'(g))
          cal_num[g] <= bus.wdata;
        if (wr && hit_calo && ix_calo == 3'(g))
          cal_off[g] <= bus.wdata;
      end
    end

    // local forcing
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        o_forced_in[g]  <= 1'b0;
        o_forced_out[g] <= 1'b0;
        fin_val[g]      <= 16'h0000;
        fout_val[g]     <= 16'h0000;
      end
      else if (sel_op && i_op_cmd == aioc_pkg::OP_FORCE_IN)
      begin
        o_forced_in[g] <= 1'b1;
        fin_val[g]     <= i_op_data;
      end
      else if (sel_op && i_op_cmd == aioc_pkg::OP_FORCE_OUT)
      begin
        o_forced_out[g] <= 1'b1;
        fout_val[g]     <= i_op_data;
      end
      else if (sel_op && i_op_cmd == aioc_pkg::OP_RELEASE)
      begin
        o_forced_in[g]  <= 1'b0;
        o_forced_out[g] <= 1'b0;
      end
    end

    // output drive, latched on the update tick
    aioc_scale u_scale (
      .i_setpt (o_forced_out[g] ? fout_val[g] : setpt[g]),
      .i_num   (cal_num[g]),
      .i_off   (cal_off[g]),
      .o_code  (code[g])
    );
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        o_dac_code[12*g +: 12] <= 12'h000;
      else if (ao_tick)
        o_dac_code[12*g +: 12] <= code[g];
    end
  end
endmodule : aioc_device

// ### aioc_host.sv
// host end: takes user register commands, screens them, runs the link
// assumes the device answers each request with one ack on the same clock
`timescale 1ns/100ps
module aioc_host (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  aioc_if.hst              bus,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_we,
  input  wire logic        i_cmd_inreg,
  input  wire logic [7:0]  i_cmd_addr,
  input  wire logic [15:0] i_cmd_wdata,
  output logic             o_cmd_ready,
  output logic             o_rsp_valid,
  output logic             o_rsp_err,
  output logic             o_rsp_refused,
  output logic [15:0]      o_rsp_data
);
  aioc_pkg::aioc_hst_t state;

  // screening of commands before they reach the link
  wire [7:0] a       = i_cmd_addr;
  wire       is_rsvd = i_cmd_inreg && (a >= aioc_pkg::ADR_RSVD) && (a < aioc_pkg::ADR_SUPPLY);
  wire       is_sp   = !i_cmd_inreg && (a >= aioc_pkg::ADR_SETPT) &&
                       (a < aioc_pkg::ADR_SETPT + 8'(aioc_pkg::NCH));
  wire       is_mode = !i_cmd_inreg && (a >= aioc_pkg::ADR_MODE) &&
                       (a < aioc_pkg::ADR_MODE + 8'(aioc_pkg::NCH));
  wire       sp_bad  = is_sp && ((i_cmd_wdata < aioc_pkg::SP_MIN) ||
                                 (i_cmd_wdata > aioc_pkg::SP_MAX));
  wire       md_bad  = is_mode && (i_cmd_wdata > aioc_pkg::MODE_MAX);
  wire       refuse  = is_rsvd ||
                       (i_cmd_we && (i_cmd_inreg || sp_bad ||
                                     md_bad));
  wire       take    = (state == aioc_pkg::ST_IDLE) && o_cmd_ready && i_cmd_valid;

  // sequencer and link drive
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state         <= aioc_pkg::ST_IDLE;
      o_cmd_ready   <= 1'b0;
      o_rsp_valid   <= 1'b0;
      o_rsp_err     <= 1'b0;
      o_rsp_refused <= 1'b0;
      o_rsp_data    <= 16'h0000;
      bus.req       <= 1'b0;
      bus.we        <= 1'b0;
      bus.inreg     <= 1'b0;
      bus.addr      <= 8'h00;
      bus.wdata     <= 16'h0000;
    end
    else
    begin
      bus.req       <= 1'b0;
      o_rsp_valid   <= 1'b0;
      o_rsp_err     <= 1'b0;
      o_rsp_refused <= 1'b0;
      unique case (state)
        aioc_pkg::ST_IDLE:
        begin
          o_cmd_ready <= 1'b1;
          if (take && refuse)
          begin
            o_rsp_valid   <= 1'b1;
            o_rsp_err     <= 1'b1;
            o_rsp_refused <= 1'b1;
            o_rsp_data    <= 16'h0000;
          end
          else if (take)
          begin
            bus.req     <= 1'b1;
            bus.we      <= i_cmd_we;
            bus.inreg   <= i_cmd_inreg;
            bus.addr    <= i_cmd_addr;
            bus.wdata   <= i_cmd_wdata;
            o_cmd_ready <= 1'b0;
            state       <= aioc_pkg::ST_WAIT;
          end
        end
        aioc_pkg::ST_WAIT:
        begin
          if (bus.ack)
          begin
            o_rsp_valid <= 1'b1;
            o_rsp_err   <= bus.err;
            o_rsp_data  <= bus.rdata;
            o_cmd_ready <= 1'b1;
            state       <= aioc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule : aioc_host

// ### aioc_asserts.sv
// link checker: watches the register link between host end and device end
// assumes one clock for both ends and a synchronous active-high reset
`timescale 1ns/100ps
module aioc_asserts (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic        inreg,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic [15:0] rdata
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // request shapes seen on the link
  sequence s_mode_hit;
    req && !inreg && addr >= 8'h85 && addr <= 8'h8C;
  endsequence
  sequence s_answer_ok;
    ack && !err;
  endsequence

  // answer timing
  a_ack_after_req : assert property (req |=> ack)
    else $error("no answer one cycle after request");
  a_ack_has_cause : assert property (ack |-> $past(req))
    else $error("answer without a request");
  a_ack_one_cycle : assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  // refusals and accepted accesses
  a_in_write_err : assert property (req && inreg |-> !we)
    else $error("write sent to input space");
  a_mode_bad_err : assert property (s_mode_hit ##0 we |-> wdata <= 16'h0002)
    else $error("bad mode code sent on link");
  a_mode_good_ok : assert property (s_mode_hit ##0 (we && wdata <= 16'h0002) |=> s_answer_ok)
    else $error("good mode code flagged");
  a_mode_read_ok : assert property (s_mode_hit ##0 !we |=> s_answer_ok ##0 rdata <= 16'h0002)
    else $error("mode readback out of range");
  a_interval_ok : assert property (req && !inreg && addr == 8'h84 |=> s_answer_ok)
    else $error("interval access flagged");
  a_tot_pair_ok : assert property (req && !inreg && addr >= 8'h11 && addr <= 8'h20 |=> s_answer_ok)
    else $error("totalizer access flagged");
  a_supply_read : assert property (req && !we && inreg && addr == 8'hFA |=> s_answer_ok)
    else $error("supply read flagged");
  a_write_rdata_zero : assert property (req && we |=> rdata == 16'h0000)
    else $error("write answer carries data");
endmodule : aioc_asserts

// ### tb_analog_io_register_control.sv
// testbench: host end and device end joined over the register link
// assumes shortened timing parameters; adc and operator are driven here
`timescale 1ns/100ps
module tb_analog_io_register_control;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        c_valid = 1'b0, c_we = 1'b0, c_in = 1'b0, ready, rsp_v, rsp_err, rsp_ref, r_err, r_ref;
  logic [7:0]  c_addr = 8'h00, f_in;
  logic [15:0] c_data = 16'h0000, rsp_data, r_data, msb, adc_data = 16'h0000, sp, num, off;
  logic        adc_start, adc_done = 1'b0, op_v = 1'b0, nv_we;
  logic [2:0]  adc_ch, op_ch = 3'h0;
  logic [3:0]  adc_cnt = 4'h0;
  logic [15:0] supply = 16'h008F, nv_mode = 16'h0004, op_data = 16'h0000;
  logic [1:0]  op_cmd = 2'h0;
  logic [95:0] dac;
  int          seed = 37, n_fail = 0, num_checks = 0, cyc = 0, nv_cnt = 0;
  localparam logic [7:0]  RST_ADR [4] = '{8'h01, 8'hA1, 8'hBA, 8'h84};
  localparam logic [15:0] RST_VAL [4] = '{16'h0FA0, 16'hFFFF, 16'h0000, 16'h0001};
  // refused or flagged requests: we, input space, addr, data, refused by host
  localparam logic [26:0] BAD [6] = '{{2'b10, 8'h01, 16'h0F9F, 1'b1}, {2'b10, 8'h01, 16'h4E21, 1'b1},
    {2'b10, 8'h85, 16'h0003, 1'b1}, {2'b11, 8'h01, 16'h0000, 1'b1}, {2'b01, 8'hF8, 16'h0000, 1'b1},
    {2'b00, 8'h83, 16'h0000, 1'b0}};

  aioc_if aioc_if_i ();
  aioc_device #(.MS_CYC(10), .AIN_CYC(20), .AOUT_CYC(16)) aioc_device_i (.i_clk(clk), .i_rst(rst),
    .bus(aioc_if_i.dev), .o_adc_start(adc_start), .o_adc_ch(adc_ch), .i_adc_done(adc_done),
    .i_adc_data(adc_data), .i_supply_tenths(supply), .i_nv_mode(nv_mode), .o_nv_we(nv_we), .o_nv_ch(),
    .o_nv_mode(), .i_op_valid(op_v), .i_op_cmd(op_cmd), .i_op_ch(op_ch), .i_op_data(op_data),
    .o_forced_in(f_in), .o_forced_out(), .o_dac_code(dac), .o_dac_upd());
  aioc_host aioc_host_i (.i_clk(clk), .i_rst(rst), .bus(aioc_if_i.hst), .i_cmd_valid(c_valid),
    .i_cmd_we(c_we), .i_cmd_inreg(c_in), .i_cmd_addr(c_addr), .i_cmd_wdata(c_data), .o_cmd_ready(ready),
    .o_rsp_valid(rsp_v), .o_rsp_err(rsp_err), .o_rsp_refused(rsp_ref), .o_rsp_data(rsp_data));
  aioc_asserts aioc_asserts_i (.i_clk(clk), .i_rst(rst), .req(aioc_if_i.req), .we(aioc_if_i.we),
    .inreg(aioc_if_i.inreg), .addr(aioc_if_i.addr), .wdata(aioc_if_i.wdata), .ack(aioc_if_i.ack),
    .err(aioc_if_i.err), .rdata(aioc_if_i.rdata));

  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (nv_we === 1'b1)
      nv_cnt++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // adc stand-in: code per channel, done pulse a few cycles after start
  always @(posedge clk)
  begin
    if (adc_start === 1'b1)
    begin
      adc_cnt  <= 4'h6;
      adc_data <= {1'b1, 4'h0, adc_ch, 8'h00};
    end
    else if (adc_cnt != 4'h0)
      adc_cnt <= adc_cnt - 4'h1;
    adc_done <= (adc_cnt != 4'h0) && (adc_cnt < 4'h4);
  end

  function automatic logic [15:0] exp_rd(input logic [1:0] m, input logic [15:0] raw);
    logic [31:0] g;
    g = (m == aioc_pkg::MODE_MA) ? 32'(aioc_pkg::GAIN_MA) : 32'(aioc_pkg::GAIN_VOLT);
    return (m == aioc_pkg::MODE_RAW) ? raw : 16'((32'(raw) * g) >> 16);
  endfunction : exp_rd

  function automatic logic [11:0] exp_dac(input logic [15:0] s, n, o);
    longint v;
    v = longint'(s) * longint'(n) / longint'(32'h0000_FFFF) + longint'($signed(o));
    return v[63] ? 12'h000 : (v > longint'(32'h0000_0FFF)) ? 12'hFFF : v[11:0];
  endfunction : exp_dac

  task automatic chk_val(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, exp);
    chk_val({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask : chk_flag

  task automatic done_test(input string s);
    $display("test %s done", s);
  endtask : done_test

  // one host command, waits for its response
  task automatic xfer(input logic we, in, input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    c_valid <= 1'b1;
    c_we    <= we;
    c_in    <= in;
    c_addr  <= a;
    c_data  <= d;
    @(posedge clk);
    c_valid <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (rsp_v !== 1'b1 && k < 40);
    chk_flag(rsp_v, 1'b1);
    r_err  = rsp_err;
    r_ref  = rsp_ref;
    r_data = rsp_data;
  endtask : xfer

  // one operator command
  task automatic op(input logic [1:0] c, input logic [2:0] ch, input logic [15:0] d);
    @(posedge clk);
    op_v    <= 1'b1;
    op_cmd  <= c;
    op_ch   <= ch;
    op_data <= d;
    @(posedge clk);
    op_v <= 1'b0;
    repeat (3) @(negedge clk);
  endtask : op

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, 1'b0, RST_ADR[i], 16'h0000);
      chk_val(r_data, RST_VAL[i]);
    end
    done_test("reset values");
    for (int i = 0; i < 6; i++)
    begin
      xfer(BAD[i][26], BAD[i][25], BAD[i][24:17], BAD[i][16:1]);
      chk_flag(r_ref, BAD[i][0]);
      chk_flag(r_err, 1'b1);
    end
    done_test("refusals");
    for (int i = 0; i < 8; i++)
    begin
      sp = (i == 0) ? 16'h0FA0 : (i == 1) ? 16'h4E20 : 16'(32'h0FA0 + $unsigned($random(seed)) % 32'h3E81);
      xfer(1'b1, 1'b0, 8'(8'h01 + i), sp);
      xfer(1'b0, 1'b0, 8'(8'h01 + i), 16'h0000);
      chk_val(r_data, sp);
    end
    done_test("setpoints");
    for (int i = 0; i < 4; i++)
    begin
      sp  = (i == 0) ? 16'h4E20 : (i == 1) ? 16'h0FA0 : 16'(32'h0FA0 + $unsigned($random(seed)) % 32'h3E81);
      num = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      off = (i == 1) ? 16'hFFFB : 16'($random(seed) % 256);
      xfer(1'b1, 1'b0, 8'h01, sp);
      xfer(1'b1, 1'b0, 8'hA1, num);
      xfer(1'b1, 1'b0, 8'hBA, off);
      repeat (40) @(negedge clk);
      chk_val(dac[11:0], exp_dac(sp, num, off));
    end
    done_test("output drive");
    xfer(1'b1, 1'b0, 8'h84, 16'h0000);
    for (int m = 2; m >= 0; m--)
    begin
      xfer(1'b1, 1'b0, 8'h85, 16'(m));
      repeat (200) @(negedge clk);
      xfer(1'b0, 1'b0, 8'h85, 16'h0000);
      chk_val(r_data, 16'(m));
      xfer(1'b0, 1'b1, 8'h01, 16'h0000);
      chk_val(r_data, exp_rd(2'(m), 16'h8000));
    end
    xfer(1'b0, 1'b1, 8'h02, 16'h0000);
    chk_val(r_data, exp_rd(2'h1, 16'h8100));
    for (int i = 2; i < 8; i++)
    begin
      xfer(1'b0, 1'b1, 8'(8'h01 + i), 16'h0000);
      chk_val(r_data, {1'b1, 4'h0, 3'(i), 8'h00});
    end
    xfer(1'b0, 1'b1, 8'hFA, 16'h0000);
    chk_val(r_data, 16'h008F);
    done_test("inputs");
    xfer(1'b1, 1'b0, 8'h11, 16'hFFFF);
    xfer(1'b1, 1'b0, 8'h12, 16'hFFFF);
    xfer(1'b0, 1'b0, 8'h11, 16'h0000);
    chk_val(r_data, 16'hFFFF);
    xfer(1'b1, 1'b0, 8'h84, 16'h0001);
    repeat (200) @(negedge clk);
    xfer(1'b1, 1'b0, 8'h84, 16'h0000);
    xfer(1'b0, 1'b0, 8'h11, 16'h0000);
    msb = r_data;
    xfer(1'b0, 1'b0, 8'h12, 16'h0000);
    chk_val(r_data[14:0], 15'h7FFF);
    chk_flag(msb > 16'h0000 && msb < 16'h0100, 1'b1);
    done_test("totalizer");
    op(aioc_pkg::OP_FORCE_IN, 3'h3, 16'h1234);
    chk_val(f_in, 8'h08);
    xfer(1'b0, 1'b1, 8'h04, 16'h0000);
    chk_val(r_data, 16'h1234);
    op(aioc_pkg::OP_RELEASE, 3'h3, 16'h0000);
    chk_val(f_in, 8'h00);
    op(aioc_pkg::OP_SET_MODE, 3'h2, 16'h0001);
    repeat (200) @(negedge clk);
    xfer(1'b0, 1'b0, 8'h87, 16'h0000);
    chk_val(r_data, 16'h0001);
    xfer(1'b0, 1'b1, 8'h03, 16'h0000);
    chk_val(r_data, exp_rd(2'h1, 16'h8200));
    done_test("operator");
    chk_val(nv_cnt, 32'h0000_0004);
    end_of_test();
  end
endmodule : tb_analog_io_register_control
